// File: rtl/cgh_config.sv
`timescale 1ns/1ps
module cgh_config (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_frame_end,
	input wire logic i_rd_req,
	input wire logic [cgh_pkg::SEL_W-1:0] i_rd_sel,
	output logic [7:0] o_rd_data,
	output logic [7:0] o_tx_gain,
	output logic [7:0] o_rx_gain,
	output logic o_rx_mute,
	output logic o_echo_en,
	output logic o_echo_noninv,
	output logic o_high_band_en,
	output logic [cgh_pkg::ATTEN_W-1:0] o_atten,
	output logic o_low_band_en,
	output logic [7:0] o_low_band_set,
	output logic [3:0] o_high_pole,
	output logic [3:0] o_high_zero
);
	import cgh_pkg::*;

	logic wr;
	logic [SEL_W-1:0] wsel;
	logic [7:0] wdata;

	cgh_byte_rx u_rx (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_byte_valid(i_byte_valid),
		.i_byte(i_byte),
		.i_frame_end(i_frame_end),
		.o_wr(wr),
		.o_sel(wsel),
		.o_data(wdata)
	);

	logic [7:0] tx_q, tx_d, rx_q, rx_d, ec_q, ec_d, lb_q, lb_d, hb_q, hb_d;
	logic [7:0] rd_q, rd_d;
	logic [4:0] atten_clip;

	always_comb begin
		tx_d = tx_q;
		rx_d = rx_q;
		ec_d = ec_q;
		lb_d = lb_q;
		hb_d = hb_q;
		if (wr) begin
			unique case (wsel)
				{1'b0, SEL_TX_GAIN}: tx_d = wdata;
				{1'b0, SEL_RX_GAIN}: rx_d = wdata;
				{1'b0, SEL_ECHO_CTRL}: ec_d = wdata;
				{1'b0, SEL_LOW_BAND}: lb_d = wdata;
				SEL_HIGH_BAND: hb_d = wdata;
				default: ;
			endcase
		end
		rd_d = rd_q;
		if (i_rd_req) begin
			unique case (i_rd_sel)
				{1'b0, SEL_TX_GAIN}: rd_d = tx_q;
				{1'b0, SEL_RX_GAIN}: rd_d = rx_q;
				{1'b0, SEL_ECHO_CTRL}: rd_d = ec_q;
				{1'b0, SEL_LOW_BAND}: rd_d = lb_q;
				SEL_HIGH_BAND: rd_d = hb_q;
				default: rd_d = 8'h00;
			endcase
		end
		// Codes above the documented top step saturate at -8.5 dB
		atten_clip = (ec_q[ATTEN_MSB:0] > ATTEN_MAX) ? ATTEN_MAX
			: ec_q[ATTEN_MSB:0];
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_q <= TX_GAIN_RST;
			rx_q <= RX_GAIN_RST;
			ec_q <= ECHO_CTRL_RST;
			lb_q <= LOW_BAND_RST;
			hb_q <= HIGH_BAND_RST;
			rd_q <= 8'h00;
		end else begin
			tx_q <= tx_d;
			rx_q <= rx_d;
			ec_q <= ec_d;
			lb_q <= lb_d;
			hb_q <= hb_d;
			rd_q <= rd_d;
		end
	end

	// Decoded controls, registered so every output is a flip-flop
	logic mute_q, en_q, ninv_q, hben_q, lben_q;
	logic [4:0] att_q;
	logic [7:0] lbs_q;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mute_q <= 1'b1;
			en_q <= 1'b0;
			ninv_q <= 1'b0;
			hben_q <= 1'b0;
			att_q <= 5'h00;
			lben_q <= 1'b0;
			lbs_q <= 8'h00;
		end else begin
			mute_q <= (rx_q == NO_OUTPUT_CODE);
			en_q <= ec_q[ECHO_EN_BIT];
			// Disabled filter forces polarity, high band and low band off; the attenuator code still passes
			ninv_q <= ec_q[ECHO_EN_BIT] & ec_q[ECHO_POL_BIT];
			hben_q <= ec_q[ECHO_EN_BIT] & ec_q[HIGH_BAND_EN_BIT];
			att_q <= atten_clip;
			lben_q <= ec_q[ECHO_EN_BIT] &
				(lb_q != LOW_BAND_BYPASS);
			lbs_q <= lb_q;
		end
	end

	assign o_tx_gain = tx_q;
	assign o_rx_gain = rx_q;
	assign o_rx_mute = mute_q;
	assign o_echo_en = en_q;
	assign o_echo_noninv = ninv_q;
	assign o_high_band_en = hben_q;
	assign o_atten = att_q;
	assign o_low_band_en = lben_q;
	assign o_low_band_set = lbs_q;
	assign o_high_pole = hb_q[7:4];
	assign o_high_zero = hb_q[3:0];
	assign o_rd_data = rd_q;

	property p_mute;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(rx_q == 8'h00) |=> o_rx_mute;
	endproperty
	a_mute: assert property (p_mute)
		else $error("zero receive code did not mute");
	property p_off;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!o_echo_en |-> !o_high_band_en && !o_low_band_en && !o_echo_noninv;
	endproperty
	a_off: assert property (p_off)
		else $error("section active while filter disabled");
	property p_atten;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_atten <= 5'h18;
	endproperty
	a_atten: assert property (p_atten)
		else $error("attenuator beyond top step");
	property p_tx_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(wr && wsel == 3'h0) |=> (o_tx_gain == $past(wdata));
	endproperty
	a_tx_write: assert property (p_tx_write)
		else $error("transmit gain not updated");
	property p_rx_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(wr && wsel == 3'h1) |=> (o_rx_gain == $past(wdata));
	endproperty
	a_rx_write: assert property (p_rx_write)
		else $error("receive gain not updated");
	property p_hold;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!wr |=> $stable(o_tx_gain) && $stable(o_rx_gain);
	endproperty
	a_hold: assert property (p_hold)
		else $error("gain changed without a complete write");
	property p_lowband;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(lb_q == 8'h00) |=> !o_low_band_en;
	endproperty
	a_lowband: assert property (p_lowband)
		else $error("zero low band code did not bypass");
	property p_hb;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ec_q[7] && ec_q[5]) |=> o_high_band_en;
	endproperty
	a_hb: assert property (p_hb)
		else $error("high band not inserted");

	// Multi-step path: control write, register, decoded output
	sequence s_ctrl_write;
		wr && (wsel == {1'b0, SEL_ECHO_CTRL});
	endsequence
	sequence s_ctrl_seen;
		o_echo_en == $past(wdata[ECHO_EN_BIT], 2);
	endsequence
	property p_ctrl_chain;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		s_ctrl_write |-> ##2 s_ctrl_seen;
	endproperty
	a_ctrl_chain: assert property (p_ctrl_chain)
		else $error("enable did not follow control write");
	property p_unmute;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(rx_q != NO_OUTPUT_CODE) |=> !o_rx_mute;
	endproperty
	a_unmute: assert property (p_unmute)
		else $error("nonzero receive code left output muted");
	property p_pol;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		1'b1 |=> o_echo_noninv == $past(ec_q[7] & ec_q[6]);
	endproperty
	a_pol: assert property (p_pol)
		else $error("polarity does not follow control");
	property p_hb_bypass;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!ec_q[HIGH_BAND_EN_BIT] |=> !o_high_band_en;
	endproperty
	a_hb_bypass: assert property (p_hb_bypass)
		else $error("high band active while bypassed");
	property p_atten_pass;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ec_q[4:0] <= ATTEN_MAX) |=> o_atten == $past(ec_q[4:0]);
	endproperty
	a_atten_pass: assert property (p_atten_pass)
		else $error("attenuator code not passed through");
	property p_atten_sat;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ec_q[4:0] > ATTEN_MAX) |=> o_atten == ATTEN_MAX;
	endproperty
	a_atten_sat: assert property (p_atten_sat)
		else $error("attenuator code not saturated");
	property p_lb_on;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ec_q[7] && lb_q != LOW_BAND_BYPASS) |=> o_low_band_en;
	endproperty
	a_lb_on: assert property (p_lb_on)
		else $error("low band not selected");
	property p_lb_set;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		1'b1 |=> o_low_band_set == $past(lb_q);
	endproperty
	a_lb_set: assert property (p_lb_set)
		else $error("low band setting not passed on");
	property p_ec_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		s_ctrl_write |=> ec_q == $past(wdata);
	endproperty
	a_ec_write: assert property (p_ec_write)
		else $error("control register not updated");
	property p_lb_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(wr && wsel == {1'b0, SEL_LOW_BAND}) |=> lb_q == $past(wdata);
	endproperty
	a_lb_write: assert property (p_lb_write)
		else $error("low band register not updated");
	property p_hb_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(wr && wsel == SEL_HIGH_BAND) |=> o_high_pole == $past(wdata[7:4])
			&& o_high_zero == $past(wdata[3:0]);
	endproperty
	a_hb_write: assert property (p_hb_write)
		else $error("high band setting not updated");
	property p_cfg_hold;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!wr |=> $stable(ec_q) && $stable(lb_q) && $stable(hb_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("balance setting changed without a write");
	property p_rd_tx;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_rd_req && i_rd_sel == 3'h0) |=> o_rd_data == $past(tx_q);
	endproperty
	a_rd_tx: assert property (p_rd_tx)
		else $error("read of transmit gain wrong");
	property p_rd_hold;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!i_rd_req |=> $stable(o_rd_data);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without a request");
endmodule // cgh_config

// File: rtl/cgh_pkg.sv
package cgh_pkg;
	localparam int GAIN_W = 8;
	localparam int FIELD_W = 8;
	// Register selectors on the write port
	localparam logic [1:0] SEL_TX_GAIN = 2'h0;
	localparam logic [1:0] SEL_RX_GAIN = 2'h1;
	localparam logic [1:0] SEL_ECHO_CTRL = 2'h2;
	localparam logic [1:0] SEL_LOW_BAND = 2'h3;
	// Field positions of the echo cancel control register
	localparam int ECHO_EN_BIT = 7;
	localparam int ECHO_POL_BIT = 6;
	localparam int HIGH_BAND_EN_BIT = 5;
	localparam int ATTEN_MSB = 4;
	localparam int ATTEN_W = 5;
	localparam logic [4:0] ATTEN_MAX = 5'h18;
	// Reset values, then the no-output and low band bypass codes
	localparam logic [7:0] TX_GAIN_RST = 8'h00;
	localparam logic [7:0] RX_GAIN_RST = 8'h00;
	localparam logic [7:0] ECHO_CTRL_RST = 8'h00;
	localparam logic [7:0] LOW_BAND_RST = 8'h00;
	localparam logic [7:0] HIGH_BAND_RST = 8'h00;
	localparam logic [7:0] NO_OUTPUT_CODE = 8'h00;
	localparam logic [7:0] LOW_BAND_BYPASS = 8'h00;
	// Instruction index of the high band register
	localparam logic [2:0] SEL_HIGH_BAND = 3'h4;
	localparam int SEL_W = 3;
endpackage

// File: rtl/cgh_byte_rx.sv
`timescale 1ns/1ps
// Collects a two-byte instruction: selector byte, then data byte
module cgh_byte_rx (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_frame_end,
	output logic o_wr,
	output logic [cgh_pkg::SEL_W-1:0] o_sel,
	output logic [7:0] o_data
);
	import cgh_pkg::*;
	logic have_sel_q, have_sel_d;
	logic [SEL_W-1:0] sel_q, sel_d;
	logic [7:0] data_q, data_d;
	logic wr_q, wr_d;

	always_comb begin
		have_sel_d = have_sel_q;
		sel_d = sel_q;
		data_d = data_q;
		wr_d = 1'b0;
		if (i_frame_end) begin
			have_sel_d = 1'b0;
		end else if (i_byte_valid && !have_sel_q) begin
			have_sel_d = 1'b1;
			sel_d = i_byte[SEL_W-1:0];
		end else if (i_byte_valid) begin
			// Write only once the whole second byte is in
			have_sel_d = 1'b0;
			data_d = i_byte;
			wr_d = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			have_sel_q <= 1'b0;
			sel_q <= '0;
			data_q <= 8'h00;
			wr_q <= 1'b0;
		end else begin
			have_sel_q <= have_sel_d;
			sel_q <= sel_d;
			data_q <= data_d;
			wr_q <= wr_d;
		end
	end

	assign o_wr = wr_q;
	assign o_sel = sel_q;
	assign o_data = data_q;

	property p_wr_pulse;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_wr |=> !o_wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe longer than one cycle");
endmodule // cgh_byte_rx

// File: verif/codec_gain_hybrid_config_tb.sv
`timescale 1ns/1ps
module codec_gain_hybrid_config_tb;
	import cgh_pkg::*;
	logic clk, nrst, bv, fe, rq;
	logic [7:0] b, rd, txg, rxg, lbs;
	logic [2:0] rs;
	logic mute, een, enon, hben, lben;
	logic [4:0] att;
	logic [3:0] hp, hz;
	int num_errors = 0, checked = 0, m[8];
	cgh_config i_cgh_config (.i_ref_clk(clk), .i_nrst(nrst), .i_byte_valid(bv),
		.i_byte(b), .i_frame_end(fe), .i_rd_req(rq), .i_rd_sel(rs),
		.o_rd_data(rd), .o_tx_gain(txg), .o_rx_gain(rxg), .o_rx_mute(mute),
		.o_echo_en(een), .o_echo_noninv(enon), .o_high_band_en(hben),
		.o_atten(att), .o_low_band_en(lben), .o_low_band_set(lbs),
		.o_high_pole(hp), .o_high_zero(hz));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd_chk(logic [2:0] s);
		rq = 1;
		rs = s;
		tick(1);
		rq = 0;
		chk("rd", rd, m[s]);
	endtask
	task automatic chk_all();
		logic [7:0] c;
		c = m[2];
		chk("tx", txg, m[0]);
		chk("rx", rxg, m[1]);
		chk("mute", {7'h0, mute}, {7'h0, m[1] == 0});
		chk("een", {7'h0, een}, {7'h0, c[7]});
		chk("pol", {7'h0, enon}, {7'h0, c[7] & c[6]});
		chk("hb", {7'h0, hben}, {7'h0, c[7] & c[5]});
		chk("att", {3'h0, att}, (c[4:0] > 24) ? 8'h18 : {3'h0, c[4:0]});
		chk("lben", {7'h0, lben}, {7'h0, c[7] & (m[3] != 0)});
		chk("lbs", lbs, m[3]);
		chk("hp", {4'h0, hp}, {4'h0, m[4][7:4]});
		chk("hz", {4'h0, hz}, {4'h0, m[4][3:0]});
		for (int s = 0; s < 8; s++) rd_chk(s[2:0]);
	endtask
	task automatic wr(logic [2:0] s, logic [7:0] d);
		bv = 1;
		b = {5'h0, s};
		tick(1);
		b = d;
		tick(1);
		bv = 0;
		if (s < 5) m[s] = d;
		tick(3);
		chk_all();
	endtask
	logic [10:0] corner[12] = '{11'h000, 11'h0ff, 11'h100, 11'h101, 11'h1ff,
		11'h298, 11'h259, 11'h23f, 11'h2e0, 11'h300, 11'h3a5, 11'h4c3};
	initial begin
		void'($urandom(32'h0f6b617b));
		{nrst, bv, fe, rq, b, rs} = '0;
		foreach (m[i]) m[i] = 0;
		repeat (5) @(posedge clk);
		#1;
		nrst = 1;
		tick(1);
		chk_all();
		foreach (corner[i]) wr(corner[i][10:8], corner[i][7:0]);
		// Level of root six volts rms gives the bare offset code
		wr(3'h0, 8'hbf);
		wr(3'h1, 8'hae);
		// Low band alone, high band left out
		wr(3'h3, 8'h5a);
		wr(3'h2, 8'h83);
		for (int i = 0; i < 40; i++) wr(3'($urandom % 8), 8'($urandom));
		bv = 1;
		b = 8'h00;
		tick(1);
		bv = 0;
		tick(4);
		chk_all();
		fe = 1;
		tick(1);
		fe = 0;
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h7f);
		test_done();
	end
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
endmodule // codec_gain_hybrid_config_tb
